// ### hw/cxb_regs_regs.svh
// constants of the transfer and bit-operation unit: offsets, flag positions, resets, cycle counts
// assumes one clock domain and the types declared in cxb_pkg
`ifndef CXB_REGS_REGS_SVH
`define CXB_REGS_REGS_SVH

// ==========================================================
// status byte bit positions
`define CXB_FLAG_C 3'h0
`define CXB_FLAG_Z 3'h1
`define CXB_FLAG_N 3'h2
`define CXB_FLAG_V 3'h3
`define CXB_FLAG_S 3'h4
`define CXB_FLAG_H 3'h5
`define CXB_FLAG_T 3'h6
`define CXB_FLAG_I 3'h7

// ==========================================================
// software register port offsets
`define CXB_OFS_RF_LAST 6'h1f
`define CXB_OFS_STATUS 6'h20
`define CXB_OFS_SP_LO 6'h21
`define CXB_OFS_SP_HI 6'h22
`define CXB_OFS_STATE 6'h23

// ==========================================================
// reset values and pointer locations
`define CXB_STATUS_RESET 8'h00
`define CXB_SP_RESET 16'h00ff
`define CXB_PTR_X_LO 5'h1a
`define CXB_PTR_Y_LO 5'h1c
`define CXB_PTR_Z_LO 5'h1e

// ==========================================================
// cycle counts per instruction class
`define CXB_CYC_ONE 1
`define CXB_CYC_MEM 2
`define CXB_CYC_PM 3

`endif

// ### hw/cxb_pkg.sv
// types of the transfer and bit-operation unit
// assumes cxb_regs_regs.svh for all numeric constants
package cxb_pkg;

	// op_flag_on/op_flag_off take the status bit index, covering every flag set/clear form
	typedef enum logic [4:0] {
		op_none, op_indirect_load, op_displaced_load, op_direct_load,
		op_indirect_write_op, op_displaced_write_op, op_direct_write_op,
		op_program_memory_load, op_program_memory_write, op_push, op_pop,
		op_io_bit_set, op_io_bit_clear, op_logical_shift_left, op_logical_shift_right,
		op_rotate_left_carry, op_rotate_right_carry, op_arith_shift_right,
		op_transfer_bit_save, op_transfer_bit_restore, op_flag_on, op_flag_off
	} cxb_op_t;

	typedef enum logic [1:0] {ptr_plain = 2'h0, ptr_post_inc = 2'h1, ptr_pre_dec = 2'h2} cxb_pmode_t;
	typedef enum logic [1:0] {ptr_x = 2'h0, ptr_y = 2'h1, ptr_z = 2'h2} cxb_ptr_t;
	typedef enum logic [1:0] {st_idle = 2'b00, st_mem = 2'b01, st_pm = 2'b11, st_spm = 2'b10} cxb_state_t;

	typedef struct packed {
		cxb_op_t op;
		logic [4:0] dst;
		logic [4:0] src;
		cxb_ptr_t ptr;
		cxb_pmode_t pmode;
		logic [2:0] bitsel;
		logic [5:0] q;
		logic [15:0] addr;
	} cxb_cmd_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cxb_dmem_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cxb_io_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic we;
		logic re;
	} cxb_pmem_t;

endpackage

// ### hw/cxb_core.sv
// execution unit for data transfer and bit instructions of an 8-bit core
// assumes decoded commands, data and io memories answering in the cycle of the request, program memory one cycle after, pmem_ack from
// the program-memory controller
`timescale 1ns/10ps
`include "cxb_regs_regs.svh"

module cxb_core
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// decoded command
	input wire logic cmd_valid,
	input wire cxb_pkg::cxb_cmd_t cmd,
	output logic cmd_ready,
	output logic done,
	// data memory
	output cxb_pkg::cxb_dmem_t dmem_req,
	input wire logic [7:0] dmem_rdata,
	// io registers
	output cxb_pkg::cxb_io_t io_req,
	input wire logic [7:0] io_rdata,
	// program memory
	output cxb_pkg::cxb_pmem_t pmem_req,
	input wire logic [15:0] pmem_rdata,
	input wire logic pmem_ack,
	// software register port
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// status
	output logic [7:0] status_byte
);

	// ==========================================================
	// state and decode
	logic [7:0] rf [0:31];
	logic [15:0] sp;
	cxb_pkg::cxb_state_t state;
	cxb_pkg::cxb_op_t op_q;
	logic [4:0] dst_q;
	logic [2:0] bit_q;
	logic z0_q;
	logic accept;
	logic [4:0] pb;
	logic [15:0] ptr_val;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [15:0] eff_addr;
	logic ptr_upd;
	logic is_mem;
	logic is_shift;
	logic [7:0] src_reg;
	logic [7:0] dst_val;
	logic [7:0] sh_res;
	logic sh_c;
	logic [7:0] next_status;
	logic [7:0] status_q;

	assign accept = cmd_valid && (state == cxb_pkg::st_idle);
	assign cmd_ready = (state == cxb_pkg::st_idle);
	assign status_byte = status_q;

	always_comb
	begin
		case (cmd.ptr)
			cxb_pkg::ptr_y: pb = `CXB_PTR_Y_LO;
			cxb_pkg::ptr_z: pb = `CXB_PTR_Z_LO;
			default: pb = `CXB_PTR_X_LO;
		endcase
	end

	assign ptr_val = {rf[pb + 5'h01], rf[pb]};
	assign ptr_inc = ptr_val + 16'h0001;
	assign ptr_dec = ptr_val - 16'h0001;
	assign src_reg = rf[cmd.src];
	assign dst_val = rf[cmd.dst];

	always_comb
	begin
		is_mem = 1'b0;
		ptr_upd = 1'b0;
		eff_addr = ptr_val;
		case (cmd.op)
			cxb_pkg::op_indirect_load, cxb_pkg::op_indirect_write_op:
			begin
				is_mem = 1'b1;
				ptr_upd = (cmd.pmode != cxb_pkg::ptr_plain);
				eff_addr = (cmd.pmode == cxb_pkg::ptr_pre_dec) ? ptr_dec : ptr_val;
			end
			cxb_pkg::op_displaced_load, cxb_pkg::op_displaced_write_op:
			begin
				is_mem = 1'b1;
				eff_addr = ptr_val + {10'h000, cmd.q};
			end
			cxb_pkg::op_direct_load, cxb_pkg::op_direct_write_op:
			begin
				is_mem = 1'b1;
				eff_addr = cmd.addr;
			end
			cxb_pkg::op_push:
			begin
				is_mem = 1'b1;
				eff_addr = sp;
			end
			cxb_pkg::op_pop:
			begin
				is_mem = 1'b1;
				eff_addr = sp + 16'h0001;
			end
			cxb_pkg::op_io_bit_set, cxb_pkg::op_io_bit_clear: is_mem = 1'b1;
			cxb_pkg::op_program_memory_load: ptr_upd = (cmd.pmode == cxb_pkg::ptr_post_inc);
			default: is_mem = 1'b0;
		endcase
	end

	// ==========================================================
	// shift and rotate unit
	always_comb
	begin
		is_shift = 1'b1;
		sh_res = dst_val;
		sh_c = status_q[`CXB_FLAG_C];
		case (cmd.op)
			cxb_pkg::op_logical_shift_left: {sh_c, sh_res} = {dst_val, 1'b0};
			cxb_pkg::op_logical_shift_right: {sh_res, sh_c} = {1'b0, dst_val};
			cxb_pkg::op_rotate_left_carry: {sh_c, sh_res} = {dst_val, status_q[`CXB_FLAG_C]};
			cxb_pkg::op_rotate_right_carry: {sh_res, sh_c} = {status_q[`CXB_FLAG_C], dst_val};
			cxb_pkg::op_arith_shift_right: {sh_res, sh_c} = {dst_val[7], dst_val};
			default: is_shift = 1'b0;
		endcase
	end

	always_comb
	begin
		next_status = status_q;
		if (reg_wr && reg_addr == `CXB_OFS_STATUS)
			next_status = reg_wdata;
		if (accept && is_shift)
		begin
			next_status[`CXB_FLAG_C] = sh_c;
			next_status[`CXB_FLAG_Z] = (sh_res == 8'h00);
			next_status[`CXB_FLAG_N] = sh_res[7];
			next_status[`CXB_FLAG_V] = sh_res[7] ^ sh_c;
			next_status[`CXB_FLAG_S] = sh_c;
		end
		if (accept && cmd.op == cxb_pkg::op_transfer_bit_save)
			next_status[`CXB_FLAG_T] = src_reg[cmd.bitsel];
		if (accept && cmd.op == cxb_pkg::op_flag_on)
			next_status[cmd.bitsel] = 1'b1;
		if (accept && cmd.op == cxb_pkg::op_flag_off)
			next_status[cmd.bitsel] = 1'b0;
	end

	// ==========================================================
	// sequencer
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state <= cxb_pkg::st_idle;
		else
		begin
			case (state)
				cxb_pkg::st_idle:
					if (accept && is_mem)
						state <= cxb_pkg::st_mem;
					else if (accept && cmd.op == cxb_pkg::op_program_memory_load)
						state <= cxb_pkg::st_mem;
					else if (accept && cmd.op == cxb_pkg::op_program_memory_write)
						state <= cxb_pkg::st_spm;
				cxb_pkg::st_mem:
					state <= (op_q == cxb_pkg::op_program_memory_load) ? cxb_pkg::st_pm : cxb_pkg::st_idle;
				cxb_pkg::st_pm: state <= cxb_pkg::st_idle;
				cxb_pkg::st_spm:
					if (pmem_ack)
						state <= cxb_pkg::st_idle;
				default: state <= cxb_pkg::st_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			op_q <= cxb_pkg::op_none;
			dst_q <= 5'h00;
			bit_q <= 3'h0;
			z0_q <= 1'b0;
		end
		else if (accept)
		begin
			op_q <= cmd.op;
			dst_q <= cmd.dst;
			bit_q <= cmd.bitsel;
			z0_q <= rf[`CXB_PTR_Z_LO][0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			done <= 1'b0;
		else
			done <= (accept && !is_mem && cmd.op != cxb_pkg::op_program_memory_load
				&& cmd.op != cxb_pkg::op_program_memory_write)
				|| (state == cxb_pkg::st_mem && op_q != cxb_pkg::op_program_memory_load)
				|| state == cxb_pkg::st_pm || (state == cxb_pkg::st_spm && pmem_ack);
	end

	// ==========================================================
	// register file, status byte and stack pointer
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 32; i++)
				rf[i] <= 8'h00;
		end
		else
		begin
			if (reg_wr && reg_addr <= `CXB_OFS_RF_LAST)
				rf[reg_addr[4:0]] <= reg_wdata;
			if (accept && ptr_upd)
			begin
				{rf[pb + 5'h01], rf[pb]} <= (cmd.pmode == cxb_pkg::ptr_pre_dec) ? ptr_dec : ptr_inc;
			end
			if (accept && is_shift)
				rf[cmd.dst] <= sh_res;
			if (accept && cmd.op == cxb_pkg::op_transfer_bit_restore)
				rf[cmd.dst][cmd.bitsel] <= status_q[`CXB_FLAG_T];
			if (state == cxb_pkg::st_mem && (op_q == cxb_pkg::op_indirect_load
				|| op_q == cxb_pkg::op_displaced_load || op_q == cxb_pkg::op_direct_load
				|| op_q == cxb_pkg::op_pop))
				rf[dst_q] <= dmem_rdata;
			if (state == cxb_pkg::st_pm)
				rf[dst_q] <= z0_q ? pmem_rdata[15:8] : pmem_rdata[7:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			status_q <= `CXB_STATUS_RESET;
		else
			status_q <= next_status;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			sp <= `CXB_SP_RESET;
		else if (accept && cmd.op == cxb_pkg::op_push)
			sp <= sp - 16'h0001;
		else if (accept && cmd.op == cxb_pkg::op_pop)
			sp <= sp + 16'h0001;
		else if (reg_wr && reg_addr == `CXB_OFS_SP_LO)
			sp[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == `CXB_OFS_SP_HI)
			sp[15:8] <= reg_wdata;
	end

	// ==========================================================
	// memory and io requests
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			dmem_req <= '0;
		else
		begin
			dmem_req.we <= 1'b0;
			dmem_req.re <= 1'b0;
			if (accept && is_mem && cmd.op != cxb_pkg::op_io_bit_set
				&& cmd.op != cxb_pkg::op_io_bit_clear)
			begin
				dmem_req.addr <= eff_addr;
				dmem_req.wdata <= src_reg;
				dmem_req.we <= cmd.op == cxb_pkg::op_indirect_write_op
					|| cmd.op == cxb_pkg::op_displaced_write_op
					|| cmd.op == cxb_pkg::op_direct_write_op || cmd.op == cxb_pkg::op_push;
				dmem_req.re <= cmd.op == cxb_pkg::op_indirect_load
					|| cmd.op == cxb_pkg::op_displaced_load
					|| cmd.op == cxb_pkg::op_direct_load || cmd.op == cxb_pkg::op_pop;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			io_req <= '0;
		else
		begin
			io_req.re <= accept && (cmd.op == cxb_pkg::op_io_bit_set || cmd.op == cxb_pkg::op_io_bit_clear);
			io_req.we <= 1'b0;
			if (accept)
				io_req.addr <= cmd.addr[4:0];
			if (state == cxb_pkg::st_mem && (op_q == cxb_pkg::op_io_bit_set
				|| op_q == cxb_pkg::op_io_bit_clear))
			begin
				io_req.we <= 1'b1;
				io_req.wdata <= io_rdata;
				io_req.wdata[bit_q] <= (op_q == cxb_pkg::op_io_bit_set);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pmem_req <= '0;
		else
		begin
			pmem_req.re <= accept && cmd.op == cxb_pkg::op_program_memory_load;
			if (accept && (cmd.op == cxb_pkg::op_program_memory_load
				|| cmd.op == cxb_pkg::op_program_memory_write))
			begin
				pmem_req.addr <= {rf[`CXB_PTR_Z_LO + 5'h01], rf[`CXB_PTR_Z_LO]};
				pmem_req.wdata <= {rf[5'h01], rf[5'h00]};
			end
			if (accept && cmd.op == cxb_pkg::op_program_memory_write)
				pmem_req.we <= 1'b1;
			else if (pmem_ack)
				pmem_req.we <= 1'b0;
		end
	end

	// ==========================================================
	// software read port
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`CXB_OFS_STATUS: reg_rdata <= status_q;
				`CXB_OFS_SP_LO: reg_rdata <= sp[7:0];
				`CXB_OFS_SP_HI: reg_rdata <= sp[15:8];
				`CXB_OFS_STATE: reg_rdata <= {6'h00, state};
				default: reg_rdata <= (reg_addr <= `CXB_OFS_RF_LAST) ? rf[reg_addr[4:0]] : 8'h00;
			endcase
		end
	end

	// ==========================================================
	// checks
	a_load_two_cycles: assert property (@(posedge sys_clk) disable iff (rst)
		accept && cmd.op == cxb_pkg::op_indirect_load |=> !cmd_ready ##1 cmd_ready && done)
		else $error("load did not finish in two cycles");
	a_pm_three_cycles: assert property (@(posedge sys_clk) disable iff (rst)
		accept && cmd.op == cxb_pkg::op_program_memory_load
		|=> state == cxb_pkg::st_mem ##1 state == cxb_pkg::st_pm ##1 cmd_ready && done)
		else $error("program load did not take three cycles");
	a_load_data_lands: assert property (@(posedge sys_clk) disable iff (rst)
		state == cxb_pkg::st_mem && op_q == cxb_pkg::op_direct_load
		|=> rf[$past(dst_q)] == $past(dmem_rdata))
		else $error("loaded byte not written to destination");
	a_post_inc_ptr: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !reg_wr && cmd.op == cxb_pkg::op_indirect_write_op
		&& cmd.pmode == cxb_pkg::ptr_post_inc
		|=> {rf[$past(pb) + 5'h01], rf[$past(pb)]} == $past(ptr_val) + 16'h0001
		&& dmem_req.we && dmem_req.addr == $past(ptr_val))
		else $error("post increment store wrong");
	a_disp_ptr_kept: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !reg_wr && cmd.op == cxb_pkg::op_displaced_load
		|=> {rf[$past(pb) + 5'h01], rf[$past(pb)]} == $past(ptr_val)
		&& dmem_req.addr == $past(ptr_val) + {10'h000, $past(cmd.q)})
		else $error("displaced load moved pointer or used wrong address");
	a_lsl_result: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !reg_wr && cmd.op == cxb_pkg::op_logical_shift_left
		|=> rf[$past(cmd.dst)] == {$past(dst_val[6:0]), 1'b0}
		&& status_q[`CXB_FLAG_C] == $past(dst_val[7]))
		else $error("left shift result or carry wrong");
	a_ror_carry: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !reg_wr && cmd.op == cxb_pkg::op_rotate_right_carry
		|=> rf[$past(cmd.dst)][7] == $past(status_q[`CXB_FLAG_C])
		&& status_q[`CXB_FLAG_C] == $past(dst_val[0]))
		else $error("rotate right through carry wrong");
	a_flag_set_only: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !reg_wr && cmd.op == cxb_pkg::op_flag_on
		|=> status_q == ($past(status_q) | (8'h01 << $past(cmd.bitsel))))
		else $error("flag set touched other flags");
	a_direct_no_flags: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !reg_wr && cmd.op == cxb_pkg::op_direct_write_op |=> $stable(status_q))
		else $error("direct store changed status");
	a_push_stack: assert property (@(posedge sys_clk) disable iff (rst)
		accept && cmd.op == cxb_pkg::op_push
		|=> sp == $past(sp) - 16'h0001 && dmem_req.we && dmem_req.addr == $past(sp))
		else $error("push stack pointer or write wrong");
	a_io_bit_rmw: assert property (@(posedge sys_clk) disable iff (rst)
		state == cxb_pkg::st_mem && op_q == cxb_pkg::op_io_bit_clear
		|=> io_req.we && io_req.wdata == ($past(io_rdata) & ~(8'h01 << $past(bit_q))))
		else $error("io bit clear wrong");

endmodule

// ### test/cxb_core_tb.sv
// testbench of the transfer and bit-operation unit: command table, flag sweep, reset checks
// assumes cxb_core with memories read combinationally and a delayed program write acknowledge
`timescale 1ns/10ps

module cxb_core_tb;

	typedef struct {
		cxb_pkg::cxb_cmd_t c;
		int cyc;
		logic [5:0] roff;
		logic [7:0] rexp;
		logic [7:0] sexp;
		logic io;
	} cxb_row_t;

	// ==========================================================
	// signals
	logic sys_clk;
	logic rst;
	logic cmd_valid;
	cxb_pkg::cxb_cmd_t cmd;
	logic cmd_ready;
	logic done;
	cxb_pkg::cxb_dmem_t dmem_req;
	logic [7:0] dmem_rdata;
	cxb_pkg::cxb_io_t io_req;
	logic [7:0] io_rdata;
	cxb_pkg::cxb_pmem_t pmem_req;
	logic [15:0] pmem_rdata;
	logic pmem_ack;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [7:0] status_byte;
	logic [7:0] dmem [0:65535];
	logic [7:0] io_mem [0:31];
	logic [2:0] ack_cnt;
	logic [15:0] pm_word;
	cxb_row_t rows [$];
	int fails;
	int total_checks;
	logic [7:0] st;
	logic [7:0] v;

	cxb_core i_dut
	(
		.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .done(done), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
		.io_req(io_req), .io_rdata(io_rdata), .pmem_req(pmem_req),
		.pmem_rdata(pmem_rdata), .pmem_ack(pmem_ack), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .status_byte(status_byte)
	);

	always #2 sys_clk = ~sys_clk;

	// ==========================================================
	// memory models
	assign dmem_rdata = dmem[dmem_req.addr];
	assign io_rdata = io_mem[io_req.addr];
	assign pmem_rdata = 16'hbeef;

	always @(posedge sys_clk)
	begin
		if (dmem_req.we)
			dmem[dmem_req.addr] <= dmem_req.wdata;
		if (io_req.we)
			io_mem[io_req.addr] <= io_req.wdata;
	end

	// program write controller stalls a few cycles before acknowledging
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ack_cnt <= 3'h0;
			pmem_ack <= 1'b0;
			pm_word <= 16'h0000;
		end
		else
		begin
			pmem_ack <= pmem_req.we && !pmem_ack && ack_cnt == 3'h3;
			ack_cnt <= (pmem_req.we && !pmem_ack) ? ack_cnt + 3'h1 : 3'h0;
			if (pmem_req.we && pmem_ack)
				pm_word <= pmem_req.wdata;
		end
	end

	// ==========================================================
	// tasks
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	function automatic cxb_pkg::cxb_cmd_t mk(input logic [4:0] op, input logic [4:0] r,
		input logic [1:0] p, input logic [1:0] m, input logic [2:0] b, input logic [5:0] q,
		input logic [15:0] a);
		mk = '{cxb_pkg::cxb_op_t'(op), r, r, cxb_pkg::cxb_ptr_t'(p),
			cxb_pkg::cxb_pmode_t'(m), b, q, a};
	endfunction

	task automatic add(input logic [4:0] op, input logic [4:0] r, input logic [1:0] p,
		input logic [1:0] m, input logic [2:0] b, input logic [5:0] q, input logic [15:0] a,
		input int cyc, input logic [5:0] ro, input logic [7:0] re, input logic [7:0] se,
		input logic io);
		rows.push_back('{mk(op, r, p, m, b, q, a), cyc, ro, re, se, io});
	endtask

	// cycles counted with the taking edge as the first; done is looked at after each edge
	task automatic run_op(input cxb_pkg::cxb_cmd_t c, input int cyc);
		int n;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		#1;
		n = 1;
		while (done !== 1'b1 && n < 50)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (cyc > 0)
			chk("op cycles", 16'(cyc), 16'(n));
		else
			chk("op done", 16'h0001, {15'h0000, done});
	endtask

	initial
	begin
		#100000;
		fails++;
		results;
	end

	// ==========================================================
	// main sequence
	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		fails = 0;
		total_checks = 0;
		foreach (dmem[i])
			dmem[i] = 8'h00;
		foreach (io_mem[i])
			io_mem[i] = 8'h00;
		dmem[16'h0100] = 8'ha5;
		dmem[16'h00ff] = 8'h5a;
		dmem[16'h0205] = 8'h77;
		dmem[16'h1234] = 8'hc3;
		io_mem[6] = 8'hff;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
		chk("done", 16'h0000, {15'h0000, done});
		reg_read(6'h20, v);
		chk("status reset", 16'h0000, {8'h00, v});
		reg_read(6'h21, v);
		chk("stack low reset", 16'h00ff, {8'h00, v});
		reg_read(6'h22, v);
		chk("stack high reset", 16'h0000, {8'h00, v});
		reg_read(6'h23, v);
		chk("state reset", 16'h0000, {8'h00, v});
		reg_write(6'h30, 8'h5a);
		reg_read(6'h30, v);
		chk("unmapped", 16'h0000, {8'h00, v});
		reg_write(6'h00, 8'h34);
		reg_write(6'h01, 8'h12);
		reg_write(6'h10, 8'h81);
		reg_write(6'h11, 8'h3c);
		reg_write(6'h1a, 8'h00);
		reg_write(6'h1b, 8'h01);
		reg_write(6'h1c, 8'h00);
		reg_write(6'h1d, 8'h02);
		reg_write(6'h1e, 8'h01);
		reg_write(6'h1f, 8'h03);
		reg_write(6'h20, 8'h2a);
		add(5'h01, 5'h0e, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 2, 6'h0e, 8'ha5, 8'h2a, 1'b0);
		add(5'h01, 5'h02, 2'h0, 2'h1, 3'h0, 6'h00, 16'h0000, 2, 6'h1a, 8'h01, 8'h2a, 1'b0);
		add(5'h01, 5'h03, 2'h0, 2'h2, 3'h0, 6'h00, 16'h0000, 2, 6'h03, 8'ha5, 8'h2a, 1'b0);
		add(5'h01, 5'h04, 2'h0, 2'h2, 3'h0, 6'h00, 16'h0000, 2, 6'h04, 8'h5a, 8'h2a, 1'b0);
		add(5'h02, 5'h05, 2'h1, 2'h0, 3'h0, 6'h05, 16'h0000, 2, 6'h05, 8'h77, 8'h2a, 1'b0);
		add(5'h03, 5'h06, 2'h0, 2'h0, 3'h0, 6'h00, 16'h1234, 2, 6'h06, 8'hc3, 8'h2a, 1'b0);
		add(5'h04, 5'h10, 2'h1, 2'h1, 3'h0, 6'h00, 16'h0000, 2, 6'h1c, 8'h01, 8'h2a, 1'b0);
		add(5'h04, 5'h11, 2'h1, 2'h2, 3'h0, 6'h00, 16'h0000, 2, 6'h1c, 8'h00, 8'h2a, 1'b0);
		add(5'h05, 5'h11, 2'h2, 2'h0, 3'h0, 6'h03, 16'h0000, 2, 6'h1e, 8'h01, 8'h2a, 1'b0);
		add(5'h06, 5'h10, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0010, 2, 6'h10, 8'h81, 8'h2a, 1'b0);
		add(5'h03, 5'h07, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0010, 2, 6'h07, 8'h81, 8'h2a, 1'b0);
		add(5'h03, 5'h08, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0200, 2, 6'h08, 8'h3c, 8'h2a, 1'b0);
		add(5'h03, 5'h09, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0304, 2, 6'h09, 8'h3c, 8'h2a, 1'b0);
		add(5'h07, 5'h0a, 2'h2, 2'h0, 3'h0, 6'h00, 16'h0000, 3, 6'h0a, 8'hbe, 8'h2a, 1'b0);
		add(5'h07, 5'h0b, 2'h2, 2'h1, 3'h0, 6'h00, 16'h0000, 3, 6'h1e, 8'h02, 8'h2a, 1'b0);
		add(5'h07, 5'h0c, 2'h2, 2'h0, 3'h0, 6'h00, 16'h0000, 3, 6'h0c, 8'hef, 8'h2a, 1'b0);
		add(5'h09, 5'h11, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 2, 6'h21, 8'hfe, 8'h2a, 1'b0);
		add(5'h0a, 5'h0d, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 2, 6'h0d, 8'h3c, 8'h2a, 1'b0);
		add(5'h0b, 5'h00, 2'h0, 2'h0, 3'h3, 6'h00, 16'h0005, 2, 6'h05, 8'h08, 8'h2a, 1'b1);
		add(5'h0c, 5'h00, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0006, 2, 6'h06, 8'hfe, 8'h2a, 1'b1);
		add(5'h0d, 5'h10, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h10, 8'h02, 8'h39, 1'b0);
		add(5'h0e, 5'h11, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h11, 8'h1e, 8'h20, 1'b0);
		add(5'h14, 5'h00, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h11, 8'h1e, 8'h21, 1'b0);
		add(5'h0f, 5'h11, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h11, 8'h3d, 8'h20, 1'b0);
		add(5'h10, 5'h11, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h11, 8'h1e, 8'h39, 1'b0);
		add(5'h10, 5'h11, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h11, 8'h8f, 8'h2c, 1'b0);
		add(5'h11, 5'h11, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h11, 8'hc7, 8'h35, 1'b0);
		add(5'h0e, 5'h10, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h10, 8'h01, 8'h20, 1'b0);
		add(5'h0e, 5'h10, 2'h0, 2'h0, 3'h0, 6'h00, 16'h0000, 1, 6'h10, 8'h00, 8'h3b, 1'b0);
		add(5'h12, 5'h11, 2'h0, 2'h0, 3'h7, 6'h00, 16'h0000, 1, 6'h11, 8'hc7, 8'h7b, 1'b0);
		add(5'h13, 5'h10, 2'h0, 2'h0, 3'h4, 6'h00, 16'h0000, 1, 6'h10, 8'h10, 8'h7b, 1'b0);
		foreach (rows[i])
		begin
			run_op(rows[i].c, rows[i].cyc);
			reg_read(6'h20, v);
			chk("row status", {8'h00, rows[i].sexp}, {8'h00, v});
			if (rows[i].io)
				v = io_mem[rows[i].roff[4:0]];
			else
				reg_read(rows[i].roff, v);
			chk("row result", {8'h00, rows[i].rexp}, {8'h00, v});
		end
		st = 8'h7b;
		for (int b = 0; b < 16; b++)
		begin
			st[3'(b)] = (b >= 8);
			run_op(mk(b < 8 ? 5'h15 : 5'h14, 5'h00, 2'h0, 2'h0, 3'(b), 6'h00, 16'h0000), 1);
			reg_read(6'h20, v);
			chk("flag status", {8'h00, st}, {8'h00, v});
			chk("status port", {8'h00, st}, {8'h00, status_byte});
		end
		run_op(mk(5'h08, 5'h00, 2'h2, 2'h0, 3'h0, 6'h00, 16'h0000), 0);
		chk("program word", 16'h1234, pm_word);
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		reg_read(6'h10, v);
		chk("register after reset", 16'h0000, {8'h00, v});
		chk("status after reset", 16'h0000, {8'h00, status_byte});
		results;
	end

endmodule
